// *** logic/rmhs_debounce.sv ***
`timescale 1ns/1ps
module rmhs_debounce (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  import rmhs_pkg::*;

  // ********************
  // Sync and filter
  // ********************
  logic sync_a;
  logic sync_b;
  logic [DEB_W-1:0] count;
  logic [DEB_W-1:0] next_count;
  logic next_level;

  always_comb begin
    next_count = '0;
    next_level = level;
    if (sync_b != level) begin
      // Level changes only after a full quiet period
      if (count == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
        next_level = sync_b;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      count <= '0;
      level <= 1'b1;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      count <= next_count;
      level <= next_level;
    end
  end

  a_level_steady: assert property (@(posedge clk) disable iff (reset) sync_b == level |=> $stable(level))
    else $error("filtered level moved with a quiet pin");
endmodule

// *** logic/rmhs_sequencer.sv ***
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module rmhs_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic presence_n,
  input wire logic rear_module_eject_request,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic mgmt_power_en,
  output logic payload_power_en,
  output logic link_en,
  output logic led_blue
);
  import rmhs_pkg::*;

  // ********************
  // Input conditioning
  // ********************
  logic present_n_deb;
  logic eject_deb;
  logic eject_n_deb;

  rmhs_debounce u_presence (
    .clk(clk),
    .reset(reset),
    .pin(presence_n),
    .level(present_n_deb)
  );

  // Eject filtered inverted so its reset level reads as idle
  rmhs_debounce u_eject (
    .clk(clk),
    .reset(reset),
    .pin(~rear_module_eject_request),
    .level(eject_n_deb)
  );

  logic present;
  assign present = ~present_n_deb;
  assign eject_deb = ~eject_n_deb;

  // ********************
  // Software command pulses
  // ********************
  function automatic logic cmd(input logic [3:0] a, input logic w, input logic [31:0] d, input int b);
    cmd = w && (a == REG_CONTROL) && d[b];
  endfunction

  logic c_bus;
  logic c_ident;
  logic c_pgrant;
  logic c_rgrant;
  logic c_rdeny;
  logic c_keyed;
  assign c_bus = cmd(addr, wr, wdata, CTL_BUS_UP);
  assign c_ident = cmd(addr, wr, wdata, CTL_IDENT_DONE);
  assign c_pgrant = cmd(addr, wr, wdata, CTL_POWER_GRANT);
  assign c_rgrant = cmd(addr, wr, wdata, CTL_REMOVAL_GRANT);
  assign c_rdeny = cmd(addr, wr, wdata, CTL_REMOVAL_DENY);
  assign c_keyed = cmd(addr, wr, wdata, CTL_KEYED_OFF_DONE);

  // ********************
  // Sequencer
  // ********************
  rmhs_state_type state;
  rmhs_state_type next_state;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_EMPTY: begin
        if (present) begin
          next_state = ST_WAIT_BUS;
        end
      end
      ST_WAIT_BUS: begin
        if (c_bus) begin
          next_state = ST_READ_IDENT;
        end
      end
      ST_READ_IDENT: begin
        if (c_ident) begin
          next_state = ST_POWER_REQ;
        end
      end
      ST_POWER_REQ: begin
        if (c_pgrant) begin
          next_state = ST_LINK_ON;
        end
      end
      ST_LINK_ON: begin
        next_state = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (eject_deb) begin
          next_state = ST_REMOVAL_REQ;
        end
      end
      ST_REMOVAL_REQ: begin
        if (c_rgrant) begin
          next_state = ST_KEYED_OFF;
        end else if (c_rdeny) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_KEYED_OFF: begin
        if (c_keyed) begin
          next_state = ST_LINK_OFF;
        end
      end
      ST_LINK_OFF: begin
        next_state = ST_PAYLOAD_OFF;
      end
      ST_PAYLOAD_OFF: begin
        next_state = ST_SAFE;
      end
      ST_SAFE: begin
        if (!present) begin
          next_state = ST_EMPTY;
        end
      end
      default: begin
        next_state = ST_EMPTY;
      end
    endcase
    // Module yanked early: drop everything at once, safety first
    if (!present && state != ST_EMPTY) begin
      next_state = ST_EMPTY;
    end
  end

  // ********************
  // Outputs from state
  // ********************
  logic next_mgmt;
  logic next_payload;
  logic next_link;
  logic next_led;

  always_comb begin
    next_mgmt = (next_state != ST_EMPTY);
    next_payload = (next_state == ST_LINK_ON) || (next_state == ST_ACTIVE) ||
                   (next_state == ST_REMOVAL_REQ) || (next_state == ST_KEYED_OFF) ||
                   (next_state == ST_LINK_OFF);
    // Link stands for the module side enable after ramp-up
    next_link = (next_state == ST_ACTIVE) || (next_state == ST_REMOVAL_REQ) ||
                (next_state == ST_KEYED_OFF);
    next_led = (next_state == ST_WAIT_BUS) || (next_state == ST_SAFE);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_EMPTY;
      mgmt_power_en <= 1'b0;
      payload_power_en <= 1'b0;
      link_en <= 1'b0;
      led_blue <= 1'b0;
    end else begin
      state <= next_state;
      mgmt_power_en <= next_mgmt;
      payload_power_en <= next_payload;
      link_en <= next_link;
      led_blue <= next_led;
    end
  end

  // ********************
  // Register read
  // ********************
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  always_comb begin
    status_word = '0;
    status_word[STS_PRESENT] = present;
    status_word[STS_EJECT] = eject_deb;
    status_word[STS_MGMT_PWR] = mgmt_power_en;
    status_word[STS_PAYLOAD_PWR] = payload_power_en;
    status_word[STS_LINK_EN] = link_en;
    status_word[STS_LED] = led_blue;
    status_word[STS_READ_IDENT] = (state == ST_READ_IDENT);
    status_word[STS_POWER_REQ] = (state == ST_POWER_REQ);
    status_word[STS_FUNCTIONAL] = (state == ST_ACTIVE);
    status_word[STS_REMOVAL_REQ] = (state == ST_REMOVAL_REQ);
    status_word[STS_KEYED_OFF_REQ] = (state == ST_KEYED_OFF);
    status_word[STS_SAFE] = (state == ST_SAFE);
    next_rdata = '0;
    if (rd) begin
      unique case (addr)
        REG_STATUS: next_rdata = status_word;
        REG_STATE: next_rdata = {28'h0000000, state};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ********************
  // Checks
  // ********************
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_link_drop;
    link_en ##1 !link_en;
  endsequence

  sequence s_inserted;
    state == ST_EMPTY && present;
  endsequence

  sequence s_waiting_bus;
    state == ST_WAIT_BUS && mgmt_power_en && led_blue && !payload_power_en;
  endsequence

  sequence s_granted;
    state == ST_POWER_REQ && c_pgrant && present;
  endsequence

  // Payload leads the link by one cycle, standing in for the supply ramp
  sequence s_link_up;
    payload_power_en && !link_en ##1 payload_power_en && link_en;
  endsequence

  sequence s_denied;
    state == ST_REMOVAL_REQ && c_rdeny && !c_rgrant && present;
  endsequence

  sequence s_back_in_service;
    state == ST_ACTIVE && link_en && payload_power_en;
  endsequence

  // ********************
  // Bring-up checks
  // ********************
  a_power_needs_presence: assert property (mgmt_power_en |-> present || $past(present))
    else $error("management power on without presence");
  a_insert_powers: assert property ($rose(present) && state == ST_EMPTY |=> mgmt_power_en && led_blue)
    else $error("insertion did not enable power and led");
  a_insert_waits: assert property (s_inserted |=> s_waiting_bus)
    else $error("insertion did not wait for the bus");
  a_empty_all_off: assert property (state == ST_EMPTY |->
    !mgmt_power_en && !payload_power_en && !link_en && !led_blue)
    else $error("empty slot with an output on");
  a_payload_needs_mgmt: assert property (payload_power_en |-> mgmt_power_en)
    else $error("payload power without management power");
  a_bus_before_ident: assert property ($rose(state == ST_READ_IDENT) |-> $past(c_bus))
    else $error("identity read before bus up");
  a_wait_bus_hold: assert property (state == ST_WAIT_BUS && !c_bus && present |=> state == ST_WAIT_BUS)
    else $error("left bus wait without bus up");
  a_ident_hold: assert property (state == ST_READ_IDENT && !c_ident && present |=> state == ST_READ_IDENT)
    else $error("power requested before identity known");
  a_payload_after_grant: assert property ($rose(payload_power_en) |-> $past(c_pgrant))
    else $error("payload power without grant");
  a_power_req_hold: assert property (state == ST_POWER_REQ && !c_pgrant |=> !payload_power_en)
    else $error("payload power before negotiation ended");
  a_grant_then_link: assert property (s_granted ##1 present |-> s_link_up)
    else $error("link did not follow payload power");
  a_functional_link: assert property (state == ST_ACTIVE |-> link_en)
    else $error("functional reported without link");

  // ********************
  // Removal checks
  // ********************
  a_eject_starts: assert property (state == ST_ACTIVE && eject_deb && present |=> state == ST_REMOVAL_REQ)
    else $error("eject ignored");
  a_removal_grant: assert property (state == ST_REMOVAL_REQ && !c_rgrant |=> state != ST_KEYED_OFF)
    else $error("removal proceeded without grant");
  a_deny_returns: assert property (s_denied |=> s_back_in_service)
    else $error("denied removal did not return to service");
  a_link_needs_payload: assert property (link_en |-> payload_power_en)
    else $error("link on without payload power");
  a_link_after_keyed: assert property ($fell(link_en) && present |-> $past(c_keyed))
    else $error("link dropped before keyed links");
  a_payload_after_link: assert property (s_link_drop ##0 present |-> payload_power_en ##1 !payload_power_en)
    else $error("payload dropped out of order");
  a_safe_led: assert property (state == ST_SAFE |-> led_blue && !payload_power_en)
    else $error("safe state without led");
  a_safe_holds: assert property (state == ST_SAFE && present |=>
    state == ST_SAFE && mgmt_power_en && led_blue)
    else $error("safe state left while module present");
  a_mgmt_off_absent: assert property ($fell(mgmt_power_en) |-> !present)
    else $error("management power removed while present");
  a_yank_all_off: assert property (!present && state != ST_EMPTY |=>
    state == ST_EMPTY && !mgmt_power_en && !payload_power_en && !link_en)
    else $error("absent module left powered");

endmodule

// *** pkg/rmhs_pkg.sv ***
package rmhs_pkg;

  // ********************
  // Timing
  // ********************
  localparam int CLK_HZ = 40000000;
  // Half a millisecond of quiet; lengthen for bouncy ejector switches
  localparam int DEBOUNCE_US = 500;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000000) * DEBOUNCE_US;
  localparam int DEB_W = 18;

  // ********************
  // Register map (word index = byte offset / 4 not used; plain byte offsets)
  // ********************
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h8;

  // Control bits, write-one pulses
  localparam int CTL_BUS_UP = 0;
  localparam int CTL_IDENT_DONE = 1;
  localparam int CTL_POWER_GRANT = 2;
  localparam int CTL_REMOVAL_GRANT = 3;
  localparam int CTL_REMOVAL_DENY = 4;
  localparam int CTL_KEYED_OFF_DONE = 5;

  // Status bits
  localparam int STS_PRESENT = 0;
  localparam int STS_EJECT = 1;
  localparam int STS_MGMT_PWR = 2;
  localparam int STS_PAYLOAD_PWR = 3;
  localparam int STS_LINK_EN = 4;
  localparam int STS_LED = 5;
  localparam int STS_READ_IDENT = 6;
  localparam int STS_POWER_REQ = 7;
  localparam int STS_FUNCTIONAL = 8;
  localparam int STS_REMOVAL_REQ = 9;
  localparam int STS_KEYED_OFF_REQ = 10;
  localparam int STS_SAFE = 11;

  typedef enum logic [3:0] {
    ST_EMPTY = 4'h0,
    ST_WAIT_BUS = 4'h1,
    ST_READ_IDENT = 4'h2,
    ST_POWER_REQ = 4'h3,
    ST_LINK_ON = 4'h4,
    ST_ACTIVE = 4'h5,
    ST_REMOVAL_REQ = 4'h6,
    ST_KEYED_OFF = 4'h7,
    ST_LINK_OFF = 4'h8,
    ST_PAYLOAD_OFF = 4'h9,
    ST_SAFE = 4'hA
  } rmhs_state_type;

endpackage

// *** tb/rmhs_rear_module.sv ***
`timescale 1ns/1ps
// ********************
// Rear module and its controller
// ********************
module rmhs_rear_module (
  input wire logic clk,
  input wire logic payload_power_en,
  output logic presence_n,
  output logic rear_module_eject_request
);
  int ramp = 0;
  // Pulled up while absent, so idle reads as no module
  initial begin
    presence_n = 1'b1;
    rear_module_eject_request = 1'b0;
  end
  // Supply ramp seen by the controller before its link may come up
  always @(posedge clk) begin
    ramp <= payload_power_en ? ramp + 1 : 0;
  end
  // Plugged in only while the connector is still dark
  task automatic insert();
    @(posedge clk);
    presence_n <= 1'b0;
  endtask
  task automatic open_handle();
    @(posedge clk);
    rear_module_eject_request <= 1'b1;
  endtask
  // Eject pin has a pull-down, so it drops with the module
  task automatic remove();
    @(posedge clk);
    presence_n <= 1'b1;
    rear_module_eject_request <= 1'b0;
  endtask
endmodule

// *** tb/rmhs_sequencer_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
`define WAITF(c, n) for (int k = 0; k < (n) && !(c); k++) begin @(posedge clk); #1; end
module rmhs_sequencer_tb;
  import rmhs_pkg::*;
  logic clk, reset, wr, rd;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic presence_n, eject, mgmt_power_en, payload_power_en, link_en, led_blue;
  int err_total = 0;
  int checked = 0;
  rmhs_sequencer dut (.clk(clk), .reset(reset), .presence_n(presence_n), .rear_module_eject_request(eject),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mgmt_power_en(mgmt_power_en),
    .payload_power_en(payload_power_en), .link_en(link_en), .led_blue(led_blue));
  rmhs_rear_module rm (.clk(clk), .payload_power_en(payload_power_en), .presence_n(presence_n),
    .rear_module_eject_request(eject));
  // ********************
  // Clock, bus tasks, verdict
  // ********************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic conclude();
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_idle();
    rd_reg(REG_STATE);
    `CHK(v[3:0], ST_EMPTY)
    `CHK({mgmt_power_en, payload_power_en, link_en, led_blue}, 4'h0)
  endtask
  task automatic t_insert();
    rm.insert();
    repeat (100) @(posedge clk);
    #1;
    `CHK(mgmt_power_en, 1'b0)
    `WAITF(mgmt_power_en, DEBOUNCE_CYCLES + 100)
    `CHK(mgmt_power_en, 1'b1)
    `CHK(led_blue, 1'b1)
    `CHK(payload_power_en, 1'b0)
  endtask
  // Early commands must be ignored until the bus is up
  task automatic t_bringup();
    wr_reg(REG_CONTROL, 32'h6);
    rd_reg(REG_STATE);
    `CHK(v[3:0], ST_WAIT_BUS)
    wr_reg(REG_CONTROL, 32'h1);
    rd_reg(REG_STATUS);
    `CHK(v[STS_READ_IDENT], 1'b1)
    wr_reg(REG_CONTROL, 32'h2);
    rd_reg(REG_STATE);
    `CHK(v[3:0], ST_POWER_REQ)
    `CHK(payload_power_en, 1'b0)
    wr_reg(REG_CONTROL, 32'h4);
    `WAITF(link_en, 4)
    `CHK(payload_power_en, 1'b1)
    `CHK(rm.ramp > 0, 1'b1)
    `CHK(led_blue, 1'b0)
    rd_reg(REG_STATUS);
    `CHK(v[STS_FUNCTIONAL], 1'b1)
    rd_reg(4'hC);
    `CHK(v, 32'h0)
  endtask
  task automatic t_eject();
    rm.open_handle();
    repeat (DEBOUNCE_CYCLES + 10) @(posedge clk);
    rd_reg(REG_STATE);
    `CHK(v[3:0], ST_REMOVAL_REQ)
    `CHK(link_en, 1'b1)
    // Deny with the read strobe right behind it: one cycle back in service
    @(posedge clk);
    wr <= 1'b1;
    addr <= REG_CONTROL;
    wdata <= 32'h10;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= REG_STATE;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata[3:0], ST_ACTIVE)
    rd_reg(REG_STATE);
    `CHK(v[3:0], ST_REMOVAL_REQ)
    wr_reg(REG_CONTROL, 32'h8);
    rd_reg(REG_STATE);
    `CHK(v[3:0], ST_KEYED_OFF)
    `CHK(link_en, 1'b1)
    wr_reg(REG_CONTROL, 32'h20);
    `WAITF(!link_en, 4)
    `CHK(payload_power_en, 1'b1)
    `WAITF(!payload_power_en, 4)
    `CHK({link_en, led_blue}, 2'h0)
    `WAITF(led_blue, 4)
    `CHK(led_blue, 1'b1)
    `CHK(mgmt_power_en, 1'b1)
  endtask
  task automatic t_remove();
    rm.remove();
    repeat (100) @(posedge clk);
    #1;
    `CHK(mgmt_power_en, 1'b1)
    `WAITF(!mgmt_power_en, DEBOUNCE_CYCLES + 100)
    `CHK({mgmt_power_en, led_blue}, 2'h0)
  endtask
  initial begin
    reset = 1'b1;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_idle();
    t_insert();
    t_bringup();
    t_eject();
    t_remove();
    conclude();
  end
  // Three debounce waits dominate the run
  initial begin
    repeat (4 * DEBOUNCE_CYCLES + 10000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
